// File: core/dhp_consts.vh
// Purpose: Shared constants of the display host memory port
// Assumes: Included by bare name from the core files
// Notes: Definitions only
`ifndef DHP_CONSTS_VH
`define DHP_CONSTS_VH
`define DHP_REGION_INDEX 2'h0
`define DHP_REGION_ROWS 2'h1
`define DHP_REGION_CTRL 2'h2
`define DHP_REGION_CHARS 2'h3
`define DHP_SRC_BIT 7
`define DHP_CTRL_FLASH_EN_BIT 3
`define DHP_CHAR_RESET 8'h20
`define DHP_INDEX_RESET 8'h00
`define DHP_CTRL_RESET 8'h00
`define DHP_GLYPH_ROWS 7
`define DHP_REF_HZ 25000000
`define DHP_OSC_HZ 57000
`define DHP_FLASH_DIV 28672
`endif

// File: core/dhp_timebase.v
// Purpose: Internal oscillator emulation and flash phase timebase
// Assumes: ext_tick is a one-cycle pulse per rising edge of the slave clock
// Notes: Flash phase toggles every FLASH_DIV/2 clock ticks, one full period per FLASH_DIV
`include "dhp_consts.vh"
`default_nettype none
module dhp_timebase #(
	parameter integer REF_HZ = `DHP_REF_HZ,
	parameter integer OSC_HZ = `DHP_OSC_HZ,
	parameter integer FLASH_DIV = `DHP_FLASH_DIV
) (
	input wire ref_clk, // System clock
	input wire reset_n, // Async reset, active low
	input wire use_internal, // High: run from internal oscillator
	input wire ext_tick, // Rising edge of external clock
	input wire flash_en, // Flash attribute enabled
	output reg osc_q, // Internal oscillator level
	output reg phase_q // Flash phase, high = hidden
);
	// Half oscillator period rounds down so the oscillator never runs slow
	localparam integer HALF_I = REF_HZ / (2 * OSC_HZ) - 1;
	localparam integer FLASH_I = FLASH_DIV / 2 - 1;
	localparam [15:0] HALF_M1 = HALF_I[15:0];
	localparam [15:0] FLASH_M1 = FLASH_I[15:0];
	reg [15:0] div_q;
	reg [15:0] fl_q;
	wire int_tick;
	wire tick;

	assign int_tick = use_internal & (div_q == HALF_M1) & ~osc_q;
	assign tick = use_internal ? int_tick : ext_tick;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 16'h0000;
			osc_q <= 1'b0;
		end else if (!use_internal) begin
			div_q <= 16'h0000;
			osc_q <= 1'b0;
		end else if (div_q == HALF_M1) begin
			div_q <= 16'h0000;
			osc_q <= ~osc_q;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fl_q <= 16'h0000;
			phase_q <= 1'b0;
		end else if (!flash_en) begin
			fl_q <= 16'h0000;
			phase_q <= 1'b0;
		end else if (tick) begin
			if (fl_q == FLASH_M1) begin
				fl_q <= 16'h0000;
				phase_q <= ~phase_q;
			end else begin
				fl_q <= fl_q + 16'h0001;
			end
		end
	end
endmodule // dhp_timebase
`default_nettype wire

// File: core/dhp_host_port.v
// Purpose: Host bus access to the character store, flash map and custom glyphs
// Assumes: Bus pins are asynchronous to ref_clk and pass two flip-flops first
// Notes: Writes repeat every cycle the write is seen; the last value stands
`include "dhp_consts.vh"
`default_nettype none
module dhp_host_port #(
	parameter integer REF_HZ = `DHP_REF_HZ,
	parameter integer OSC_HZ = `DHP_OSC_HZ,
	parameter integer FLASH_DIV = `DHP_FLASH_DIV
) (
	input wire ref_clk, // 25 MHz system clock
	input wire reset_n, // Async reset, active low
	input wire clock_source_select, // High internal clock, low external
	input wire clk_in, // Clock pin input side
	output wire clk_out, // Clock pin output side
	output wire clk_oe, // Clock pin drive enable
	input wire cs_n, // Chip select, active low
	input wire store_n, // Write strobe, active low
	input wire fetch_n, // Read strobe, active low
	input wire blink_map_select, // Low selects the flash map
	input wire [2:0] position_lines, // Position or row address
	input wire [1:0] region_lines, // Region address
	input wire [7:0] data_in, // Data bus input side
	output reg [7:0] data_out, // Data bus output side
	output wire data_oe, // Data bus drive enable
	output wire [55:0] pos_code, // Per position 7-bit glyph code
	output wire [7:0] pos_custom, // Per position custom glyph flag
	output wire [7:0] pos_lit, // Per position visible after flashing
	input wire [3:0] lookup_glyph, // Custom glyph to look up
	input wire [2:0] lookup_row, // Row to look up
	output reg [4:0] lookup_dots_q // Looked up row dots
);
	reg [2:0] ctl_m_q;
	reg [2:0] ctl_s_q;
	reg [15:0] bus_m_q;
	reg [15:0] bus_s_q;
	reg clk_p_q;
	reg [7:0] chars_q [0:7];
	reg [7:0] flash_q;
	reg [7:0] index_q;
	reg flash_en_q;
	reg [4:0] rows_q [0:127];
	reg [7:0] rd_d;
	reg rd_q;
	integer i;
	wire sel_act;
	wire wr_act;
	wire rd_act;
	wire map_sel_n;
	wire [1:0] region;
	wire [2:0] pos;
	wire [7:0] wdata;
	wire cls_s;
	wire clk_s;
	wire phase;
	wire osc;
	wire [6:0] row_idx;

	// Strobes reset high so no write is seen while the synchroniser fills
	// Pins share stages with the strobes so a write sees coherent bits
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_m_q <= 3'h7;
			ctl_s_q <= 3'h7;
			bus_m_q <= 16'h0000;
			bus_s_q <= 16'h0000;
			clk_p_q <= 1'b0;
		end else begin
			ctl_m_q <= {cs_n, store_n, fetch_n};
			ctl_s_q <= ctl_m_q;
			bus_m_q <= {clock_source_select, clk_in, blink_map_select, region_lines,
				position_lines, data_in};
			bus_s_q <= bus_m_q;
			clk_p_q <= clk_s;
		end
	end

	assign sel_act = ~ctl_s_q[2];
	assign wr_act = sel_act & ~ctl_s_q[1];
	// Both strobes low counts as a write and never drives the bus
	assign rd_act = sel_act & ~ctl_s_q[0] & ctl_s_q[1];
	assign cls_s = bus_s_q[15];
	assign clk_s = bus_s_q[14];
	assign map_sel_n = bus_s_q[13];
	assign region = bus_s_q[12:11];
	assign pos = bus_s_q[10:8];
	assign wdata = bus_s_q[7:0];
	assign row_idx = {index_q[3:0], pos};

	dhp_timebase #(
		.REF_HZ(REF_HZ),
		.OSC_HZ(OSC_HZ),
		.FLASH_DIV(FLASH_DIV)
	) u_timebase (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.use_internal(cls_s),
		.ext_tick(clk_s & ~clk_p_q),
		.flash_en(flash_en_q),
		.osc_q(osc),
		.phase_q(phase)
	);

	// Gated so the output side never shows a stale level while taking a clock in
	assign clk_out = osc & cls_s;
	assign clk_oe = cls_s;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < 8; i = i + 1) begin
				chars_q[i] <= `DHP_CHAR_RESET;
			end
			for (i = 0; i < 128; i = i + 1) begin
				rows_q[i] <= 5'h00;
			end
			flash_q <= 8'h00;
			index_q <= `DHP_INDEX_RESET;
			flash_en_q <= 1'b0;
		end else if (wr_act) begin
			if (!map_sel_n) begin
				flash_q[pos] <= wdata[0];
			end else begin
				case (region)
				`DHP_REGION_INDEX: begin
					index_q <= wdata;
				end
				`DHP_REGION_ROWS: begin
					// Row 7 does not exist in a 5x7 glyph
					if (pos < `DHP_GLYPH_ROWS) begin
						rows_q[row_idx] <= wdata[4:0];
					end
				end
				`DHP_REGION_CTRL: begin
					flash_en_q <= wdata[`DHP_CTRL_FLASH_EN_BIT];
				end
				default: begin
					chars_q[pos] <= wdata;
				end
				endcase
			end
		end
	end

	always @* begin
		rd_d = 8'h00;
		if (!map_sel_n) begin
			rd_d = {7'h00, flash_q[pos]};
		end else begin
			case (region)
			`DHP_REGION_INDEX: begin
				rd_d = index_q;
			end
			`DHP_REGION_ROWS: begin
				// Missing row 7 reads back as zero
				if (pos < `DHP_GLYPH_ROWS) begin
					rd_d = {3'h0, rows_q[row_idx]};
				end
			end
			`DHP_REGION_CTRL: begin
				rd_d = {4'h0, flash_en_q, 3'h0};
			end
			default: begin
				rd_d = chars_q[pos];
			end
			endcase
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= 8'h00;
			rd_q <= 1'b0;
			lookup_dots_q <= 5'h00;
		end else begin
			data_out <= rd_d;
			rd_q <= rd_act;
			// Lookup comes from logic on this clock, so no synchroniser
			if (lookup_row < `DHP_GLYPH_ROWS) begin
				lookup_dots_q <= rows_q[{lookup_glyph, lookup_row}];
			end else begin
				lookup_dots_q <= 5'h00;
			end
		end
	end

	// Enable waits for data_out so stale data never reaches the bus; release stays prompt
	assign data_oe = rd_act & rd_q;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_pos
			wire [7:0] ent;
			assign ent = chars_q[g];
			assign pos_custom[g] = ent[`DHP_SRC_BIT];
			assign pos_code[g*7 +: 7] = ent[`DHP_SRC_BIT] ? {3'h0, ent[3:0]} :
				ent[6:0];
			// Phase is held visible while flash is off
			assign pos_lit[g] = ~(flash_en_q & flash_q[g] & phase);
		end
	endgenerate
endmodule // dhp_host_port
`default_nettype wire

// File: test/dhp_monitor.sv
// Purpose: port checks of dhp_host_port
// Assumes: pins change just after ref_clk rises
// Notes: pin paths pass two flops before acting
`default_nettype none
module dhp_monitor (
	input wire ref_clk, // clock
	input wire reset_n, // reset
	input wire clock_source_select, // clock select
	input wire cs_n, // select
	input wire store_n, // write
	input wire fetch_n, // read
	input wire clk_out, // clock out
	input wire clk_oe, // clock drive
	input wire data_oe, // bus drive
	input wire [55:0] pos_code, // codes
	input wire [7:0] pos_custom, // custom flags
	input wire [2:0] lookup_row, // row
	input wire [4:0] lookup_dots_q // dots
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire rd = !cs_n && !fetch_n && store_n;
	wire wr = !cs_n && !store_n;
	wire [55:0] hi;
	for (genvar g = 0; g < 8; g++) begin : gm
		assign hi[g*7+:7] = {7{pos_custom[g]}} & 7'h70;
	end
	AST_OE_CAUSE: assert property (data_oe |-> $past(rd, 2) || $past(rd, 3))
		else $error("bus driven without read");
	AST_OE_ON: assert property ($past(rd, 2) && $past(rd, 3) |-> data_oe)
		else $error("read not driven");
	AST_CLK_ON: assert property ($rose(clock_source_select) |-> ##[1:4] clk_oe)
		else $error("clock pin not driven");
	AST_CLK_OFF: assert property ($fell(clock_source_select) |-> ##[1:4] !clk_oe)
		else $error("clock pin still driven");
	AST_SLAVE_LOW: assert property (!clk_oe |-> !clk_out)
		else $error("clock out while slave");
	AST_OSC_RUNS: assert property (clk_oe |-> ##[1:500] ($changed(clk_out) || !clk_oe))
		else $error("oscillator stuck");
	AST_CUSTOM_IDX: assert property ((pos_code & hi) == 56'h0)
		else $error("custom index wider than four bits");
	AST_ROW7_NONE: assert property (lookup_row == 3'h7 |=> lookup_dots_q == 5'h00)
		else $error("row seven has dots");
	AST_WRITE_CAUSE: assert property ($changed({pos_code, pos_custom}) |->
		$past(wr, 2) || $past(wr, 3) || $past(wr, 4)) else $error("store changed unwritten");
	COV_READ: cover property (rd ##2 data_oe);
	COV_CUSTOM: cover property (pos_custom != 8'h00);
	COV_SLAVE: cover property ($fell(clk_oe));
endmodule // dhp_monitor
`default_nettype wire

// File: test/dhp_host_model.sv
// Purpose: shared wires: data bus and master display clock
// Assumes: one party drives the bus at a time
// Notes: a released bus flips each cycle so stale data cannot pass
`default_nettype none
module dhp_host_model (
	input wire logic ref_clk, // clock
	input wire logic clk_out, // device clock
	input wire logic clk_oe, // device drives clock
	input wire logic host_oe, // host drives bus
	input wire logic [7:0] host_d, // host data
	input wire logic [7:0] data_out, // device data
	input wire logic data_oe, // device drives bus
	output logic clk_pin, // clock wire
	output logic [7:0] bus // data wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic master = 1'b0;
	logic [7:0] last = 8'h00;
	always #400 master = ~master;
	assign clk_pin = clk_oe ? clk_out : master;
	assign bus = data_oe ? data_out : host_oe ? host_d : ~last;
	always @(posedge ref_clk) last <= bus;
endmodule // dhp_host_model
`default_nettype wire

// File: test/dhp_host_port_tb.sv
// Purpose: self-checking bench of dhp_host_port
// Assumes: pins change 1 ns after ref_clk rises
// Notes: FLASH_DIV of 8 keeps the flash runs short
`default_nettype none
module dhp_host_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, reset_n = 1'b0, sel = 1'b1, cs_n = 1'b1, store_n = 1'b1;
	logic fetch_n = 1'b1, fl = 1'b1, host_oe = 1'b0, clk_pin, clk_out, clk_oe, data_oe;
	logic [1:0] rg = 2'h3;
	logic [2:0] pos = 3'h0, row = 3'h0;
	logic [3:0] glyph = 4'h0;
	logic [4:0] dots;
	logic [7:0] host_d = 8'h00, bus, data_out, lit, custom;
	logic [55:0] code;
	int errors = 0, samples_checked = 0, n;
	dhp_host_port #(.FLASH_DIV(8)) dut_u (.ref_clk, .reset_n, .clock_source_select(sel),
		.clk_in(clk_pin), .clk_out, .clk_oe, .cs_n, .store_n, .fetch_n, .blink_map_select(fl),
		.position_lines(pos), .region_lines(rg), .data_in(bus), .data_out, .data_oe,
		.pos_code(code), .pos_custom(custom), .pos_lit(lit), .lookup_glyph(glyph),
		.lookup_row(row), .lookup_dots_q(dots));
	dhp_host_model host_u (.ref_clk, .clk_out, .clk_oe, .host_oe, .host_d, .data_out,
		.data_oe, .clk_pin, .bus);
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic f, input logic [1:0] r, input logic [2:0] p,
		input logic [7:0] d, output logic [7:0] got);
		@(posedge ref_clk) #1;
		fl = f;
		rg = r;
		pos = p;
		host_d = d;
		host_oe = w;
		cs_n = 1'b0;
		store_n = !w;
		fetch_n = w;
		repeat (4) @(posedge ref_clk) #1;
		for (int k = 0; k < 8 && !w && data_oe !== 1'b1; k++) @(posedge ref_clk) #1;
		got = bus;
		cs_n = 1'b1;
		store_n = 1'b1;
		fetch_n = 1'b1;
		repeat (3) @(posedge ref_clk) #1;
		host_oe = 1'b0;
	endtask
	task automatic wr(input logic f, input logic [1:0] r, input logic [2:0] p, input logic [7:0] d);
		logic [7:0] g;
		acc(1'b1, f, r, p, d, g);
	endtask
	task automatic rd(input logic f, input logic [1:0] r, input logic [2:0] p, input logic [7:0] e);
		logic [7:0] g;
		acc(1'b0, f, r, p, 8'h00, g);
		chk(g, e);
	endtask
	// Cycles until the flashing position next changes, capped
	task automatic gap(output int c);
		logic v;
		v = lit[3];
		for (c = 0; c < 4000 && lit[3] === v; c++) @(posedge ref_clk) #1;
	endtask
	task automatic wrap_up;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#1000000;
		errors++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge ref_clk) #1;
		reset_n = 1'b1;
		for (int i = 0; i < 8; i++) rd(1'b1, 2'h3, 3'(i), 8'h20);
		rd(1'b1, 2'h0, 3'h0, 8'h00);
		rd(1'b1, 2'h2, 3'h0, 8'h00);
		for (int i = 0; i < 8; i++) wr(1'b1, 2'h3, 3'(i), i == 3 ? 8'hf5 : 8'(8'h41 + i));
		for (int i = 0; i < 8; i++) rd(1'b1, 2'h3, 3'(i), i == 3 ? 8'hf5 : 8'(8'h41 + i));
		chk({1'b0, code[27:21]}, 8'h05);
		chk({1'b0, code[6:0]}, 8'h41);
		chk(custom, 8'h08);
		store_n = 1'b0;
		repeat (6) @(posedge ref_clk) #1;
		store_n = 1'b1;
		// Stray strobe sat on position 7, so a false write would show there
		rd(1'b1, 2'h3, 3'h7, 8'h48);
		wr(1'b1, 2'h0, 3'h0, 8'ha5);
		rd(1'b1, 2'h0, 3'h0, 8'ha5);
		for (int r = 0; r < 8; r++) wr(1'b1, 2'h1, 3'(r), 8'(8'hf0 + r));
		rd(1'b1, 2'h1, 3'h6, 8'h16);
		glyph = 4'h5;
		for (int r = 0; r < 8; r++) begin
			row = 3'(r);
			repeat (2) @(posedge ref_clk) #1;
			chk({3'h0, dots}, r == 7 ? 8'h00 : 8'(8'h10 + r));
		end
		wr(1'b1, 2'h2, 3'h0, 8'hff);
		rd(1'b1, 2'h2, 3'h0, 8'h08);
		wr(1'b0, 2'h1, 3'h3, 8'hff);
		wr(1'b0, 2'h0, 3'h4, 8'h01);
		wr(1'b0, 2'h2, 3'h4, 8'hfe);
		rd(1'b0, 2'h0, 3'h3, 8'h01);
		rd(1'b0, 2'h3, 3'h4, 8'h00);
		// Internal oscillator ticks every 438 cycles, the master display every 20
		// Third pass returns to the internal clock so the pin turns back to an output
		for (int m = 0; m < 3; m++) begin
			sel = (m != 1);
			repeat (3) gap(n);
			chk({7'h0, (n - (m == 1 ? 80 : 1752)) inside {[-2:2]}}, 8'h01);
			chk(lit | 8'h08, 8'hff);
			chk({7'h0, clk_oe}, 8'(m != 1));
		end
		wr(1'b1, 2'h2, 3'h0, 8'h00);
		repeat (8) @(posedge ref_clk) #1;
		chk(lit, 8'hff);
		wrap_up;
	end
endmodule // dhp_host_port_tb
bind dhp_host_port dhp_monitor mon_u (.ref_clk, .reset_n, .clock_source_select, .cs_n, .store_n,
	.fetch_n, .clk_out, .clk_oe, .data_oe, .pos_code, .pos_custom, .lookup_row, .lookup_dots_q);
`default_nettype wire
